/* hdl/rwu_defs.svh */
// register offsets, reset values and timing counts of the reset and watchdog unit
`ifndef RWU_DEFS_SVH
`define RWU_DEFS_SVH

// ------------------------------------------------------------------
// register indices (byte address = 4 * index)
// ------------------------------------------------------------------
`define RWU_IDX_PORT_DATA_A  8'hC0
`define RWU_IDX_PORT_DATA_B  8'hC1
`define RWU_IDX_PORT_DIR_A   8'hC4
`define RWU_IDX_PORT_DIR_B   8'hC5
`define RWU_IDX_IRQ_OPTION   8'hC8
`define RWU_IDX_PORT_OPT_A   8'hCC
`define RWU_IDX_PORT_OPT_B   8'hCD
`define RWU_IDX_OSC_CTRL     8'hD1
`define RWU_IDX_TMR_PRESC    8'hD2
`define RWU_IDX_TMR_COUNT    8'hD3
`define RWU_IDX_TMR_CTRL     8'hD4
`define RWU_IDX_WDG          8'hD8
`define RWU_IDX_STATUS       8'hE1

// ------------------------------------------------------------------
// reset values
// ------------------------------------------------------------------
`define RWU_RST_ZERO         8'h00
`define RWU_RST_OSC_CTRL     8'h40
`define RWU_RST_TMR_PRESC    8'h7F
`define RWU_RST_TMR_COUNT    8'hFF
`define RWU_RST_WDG          8'hFE
`define RWU_RST_VECTOR       12'hFFE

// ------------------------------------------------------------------
// field positions
// ------------------------------------------------------------------
`define RWU_WDG_ACT_BIT      0
`define RWU_WDG_SR_BIT       1
`define RWU_OSC_OFF_BIT      2

// ------------------------------------------------------------------
// timing counts, in internal clock cycles, except the watchdog prescaler count, which is in ticks
// ------------------------------------------------------------------
`define RWU_RST_DELAY_CYC    2048
`define RWU_TICK_DIV         12
`define RWU_WDG_MIN_PER_CYC  3072
`define RWU_WDG_PRESC_CNT    (`RWU_WDG_MIN_PER_CYC / `RWU_TICK_DIV)

`endif

/* hdl/rwu_pin_sync.sv */
// three-flop pin synchroniser that accepts a level once two stages agree
`timescale 1ns/1ps
module rwu_pin_sync #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  input  wire logic i_pin,
  output logic      o_level
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  // shift chain, first stage feeds only the second
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= i_pin;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  // accept change only when stages two and three agree
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_level <= RST_VAL;
    end else if (s2_r == s3_r) begin
      o_level <= s3_r;
    end
  end
endmodule : rwu_pin_sync

/* hdl/rwu_pkg.sv */
// types shared by the reset and watchdog unit
package rwu_pkg;

  typedef enum logic [1:0] {RWU_ST_HOLD, RWU_ST_DELAY, RWU_ST_RUN} rwu_rst_state_t;

  typedef enum logic [1:0] {RWU_PM_RUN, RWU_PM_WAIT, RWU_PM_STOP} rwu_pwr_mode_t;

  // events reported by the cpu core
  typedef struct packed {
    logic stop_exec;    // stop instruction executed, one cycle
    logic wait_exec;    // wait instruction executed, one cycle
    logic wake_irq;     // interrupt that ends stop or wait, one cycle
    logic return_from_interrupt;         // return_from_interrupt executed, one cycle
    logic irq_pending;  // some interrupt is pending, level
  } rwu_core_evt_t;

  // controls sent to the cpu core
  typedef struct packed {
    logic        halt;
    logic        stack_clear;
    logic        pc_load;
    logic [11:0] pc_vector;
    logic        nmi_mode;
    logic        irq_service;
  } rwu_core_ctl_t;

endpackage : rwu_pkg

/* hdl/rwu_tick_div.sv */
// divide-by-twelve tick enable for the watchdog prescaler
`timescale 1ns/1ps
`include "rwu_defs.svh"
module rwu_tick_div (
  input  wire logic i_ref_clk,
  input  wire logic i_reset,
  output logic      o_tick
);
  localparam logic [3:0] LAST = 4'(`RWU_TICK_DIV - 1);

  logic [3:0] cnt_r;

  // modulo counter with one-cycle pulse on wrap
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cnt_r  <= 4'h0;
      o_tick <= 1'b0;
    end else begin
      o_tick <= (cnt_r == LAST);
      cnt_r  <= (cnt_r == LAST) ? 4'h0 : cnt_r + 4'h1;
    end
  end
endmodule : rwu_tick_div

/* hdl/rwu_top.sv */
// reset sequencer, watchdog and register file of the reset and watchdog unit
`timescale 1ns/1ps
`include "rwu_defs.svh"
module rwu_top (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_reset_pin_n,
  input  wire logic                   i_por,
  input  wire logic                   i_nmi_pin,
  input  wire logic                   i_opt_hw_wdg,
  input  wire logic                   i_opt_ext_stop,
  input  wire rwu_pkg::rwu_core_evt_t i_core_evt,
  input  wire logic                   i_psel,
  input  wire logic                   i_penable,
  input  wire logic                   i_pwrite,
  input  wire logic [11:0]            i_paddr,
  input  wire logic [31:0]            i_pwdata,
  input  wire logic [3:0]             i_pstrb,
  output logic [31:0]                 o_prdata,
  output logic                        o_pready,
  output logic                        o_pslverr,
  output logic                        o_int_reset,
  output logic                        o_io_pullup,
  output logic                        o_osc_restart,
  output logic                        o_osc_off,
  output logic                        o_wait_mode,
  output logic                        o_stop_mode,
  output rwu_pkg::rwu_core_ctl_t      o_core_ctl
);
  import rwu_pkg::*;

  // ------------------------------------------------------------------
  // constants
  // ------------------------------------------------------------------
  localparam int         NSLOT     = 11;
  localparam logic [3:0] NO_SLOT   = 4'hF;
  localparam logic [10:0] DLY_LAST = 11'(`RWU_RST_DELAY_CYC - 1);
  localparam logic [7:0] PRE_LAST  = 8'(`RWU_WDG_PRESC_CNT - 1);
  localparam logic [7:0] WDG_RST   = `RWU_RST_WDG;

  // ------------------------------------------------------------------
  // functions
  // ------------------------------------------------------------------
  // reverse six counter bits against register bits
  function automatic logic [5:0] rev6(input logic [5:0] x);
    logic [5:0] y;
    y = 6'h00;
    for (int i = 0; i < 6; i++) begin
      y[i] = x[5 - i];
    end
    return y;
  endfunction : rev6

  // map a register index to a plain storage slot
  function automatic logic [3:0] slot_of(input logic [7:0] idx);
    logic [3:0] s;
    s = NO_SLOT;
    unique case (idx)
      `RWU_IDX_PORT_DATA_A: s = 4'h0;
      `RWU_IDX_PORT_DATA_B: s = 4'h1;
      `RWU_IDX_PORT_DIR_A:  s = 4'h2;
      `RWU_IDX_PORT_DIR_B:  s = 4'h3;
      `RWU_IDX_PORT_OPT_A:  s = 4'h4;
      `RWU_IDX_PORT_OPT_B:  s = 4'h5;
      `RWU_IDX_IRQ_OPTION:  s = 4'h6;
      `RWU_IDX_TMR_CTRL:    s = 4'h7;
      `RWU_IDX_TMR_COUNT:   s = 4'h8;
      `RWU_IDX_TMR_PRESC:   s = 4'h9;
      `RWU_IDX_OSC_CTRL:    s = 4'hA;
      default:              s = NO_SLOT;
    endcase
    return s;
  endfunction : slot_of

  // reset value of each plain slot
  function automatic logic [7:0] slot_rst(input int s);
    logic [7:0] v;
    v = `RWU_RST_ZERO;
    if (s == 8) v = `RWU_RST_TMR_COUNT;
    if (s == 9) v = `RWU_RST_TMR_PRESC;
    if (s == 10) v = `RWU_RST_OSC_CTRL;
    return v;
  endfunction : slot_rst

  // ------------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------------
  logic           pin_n_s;
  logic           por_s;
  logic           nmi_s;
  logic           tick;
  rwu_rst_state_t state_r;
  rwu_rst_state_t state_nxt;
  rwu_pwr_mode_t  pm_r;
  logic [10:0]    dly_r;
  logic           hw_opt_r;
  logic           ext_stop_r;
  logic [7:0]     plain_r [0:NSLOT-1];
  logic [6:0]     cnt_r;
  logic           act_r;
  logic [7:0]     pre_r;
  logic           wdg_fire_r;
  logic           sw_fire_r;
  logic [3:0]     cause_r;
  logic           src;
  logic           in_reset;
  logic           wdg_act;
  logic           frozen;
  logic           wdg_step;
  logic           stop_as_wait;
  logic           acc;
  logic           wr_fire;
  logic [7:0]     idx;
  logic [3:0]     slot;
  logic           hit;
  logic [7:0]     wdg_rd;
  logic [7:0]     stat_rd;
  logic [7:0]     wb;

  // ------------------------------------------------------------------
  // pin inputs and tick
  // ------------------------------------------------------------------
  rwu_pin_sync #(.RST_VAL(1'b0)) u_sync_rst (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_pin     (i_reset_pin_n),
    .o_level   (pin_n_s)
  );
  rwu_pin_sync #(.RST_VAL(1'b1)) u_sync_por (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_pin     (i_por),
    .o_level   (por_s)
  );
  rwu_pin_sync #(.RST_VAL(1'b0)) u_sync_nmi (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .i_pin     (i_nmi_pin),
    .o_level   (nmi_s)
  );
  rwu_tick_div u_tick (
    .i_ref_clk (i_ref_clk),
    .i_reset   (i_reset),
    .o_tick    (tick)
  );

  // ------------------------------------------------------------------
  // reset sequencer
  // ------------------------------------------------------------------
  // any source holds the internal reset
  assign src      = ~pin_n_s | por_s | wdg_fire_r | sw_fire_r;
  assign in_reset = (state_r != RWU_ST_RUN);

  // next reset state
  always_comb begin
    state_nxt = state_r;
    unique case (state_r)
      RWU_ST_HOLD:  if (!src) state_nxt = RWU_ST_DELAY;
      RWU_ST_DELAY: begin
        if (src) begin
          state_nxt = RWU_ST_HOLD;
        end else if (dly_r == DLY_LAST) begin
          state_nxt = RWU_ST_RUN;
        end
      end
      RWU_ST_RUN:   if (src) state_nxt = RWU_ST_HOLD;
    endcase
  end

  // state and stabilisation counter
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      state_r <= RWU_ST_HOLD;
      dly_r   <= 11'h000;
    end else begin
      state_r <= state_nxt;
      dly_r   <= (state_r == RWU_ST_DELAY && !src) ? dly_r + 11'h001 : 11'h000;
    end
  end

  // mask options caught while in reset
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      hw_opt_r   <= 1'b0;
      ext_stop_r <= 1'b0;
    end else if (in_reset) begin
      hw_opt_r   <= i_opt_hw_wdg;
      ext_stop_r <= i_opt_ext_stop;
    end
  end

  // reset-facing outputs
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_int_reset   <= 1'b1;
      o_io_pullup   <= 1'b1;
      o_osc_restart <= 1'b0;
      o_osc_off     <= 1'b0;
    end else begin
      o_int_reset   <= (state_nxt != RWU_ST_RUN);
      o_io_pullup   <= (state_nxt != RWU_ST_RUN);
      o_osc_restart <= (state_r == RWU_ST_RUN) && src;
      o_osc_off     <= (state_nxt == RWU_ST_RUN) && plain_r[10][`RWU_OSC_OFF_BIT];
    end
  end

  // ------------------------------------------------------------------
  // core controls
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_core_ctl <= '{halt: 1'b1, stack_clear: 1'b0, pc_load: 1'b0,
                      pc_vector: `RWU_RST_VECTOR, nmi_mode: 1'b1, irq_service: 1'b0};
    end else begin
      o_core_ctl.halt        <= (state_nxt != RWU_ST_RUN);
      o_core_ctl.pc_vector   <= `RWU_RST_VECTOR;
      o_core_ctl.stack_clear <= in_reset && (state_nxt == RWU_ST_RUN);
      o_core_ctl.pc_load     <= in_reset && (state_nxt == RWU_ST_RUN);
      o_core_ctl.irq_service <= !in_reset && i_core_evt.return_from_interrupt && o_core_ctl.nmi_mode
                                && i_core_evt.irq_pending;
      if (state_nxt != RWU_ST_RUN) begin
        o_core_ctl.nmi_mode <= 1'b1;
      end else if (i_core_evt.return_from_interrupt) begin
        o_core_ctl.nmi_mode <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------------
  // power modes
  // ------------------------------------------------------------------
  assign wdg_act      = act_r | hw_opt_r;
  assign stop_as_wait = wdg_act && !(ext_stop_r && nmi_s);
  assign frozen       = (pm_r == RWU_PM_STOP);

  always_ff @(posedge i_ref_clk) begin
    if (i_reset || in_reset) begin
      pm_r <= RWU_PM_RUN;
    end else if (i_core_evt.wake_irq) begin
      pm_r <= RWU_PM_RUN;
    end else if (pm_r == RWU_PM_RUN && i_core_evt.stop_exec) begin
      pm_r <= stop_as_wait ? RWU_PM_WAIT : RWU_PM_STOP;
    end else if (pm_r == RWU_PM_RUN && i_core_evt.wait_exec) begin
      pm_r <= RWU_PM_WAIT;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_wait_mode <= 1'b0;
      o_stop_mode <= 1'b0;
    end else begin
      o_wait_mode <= (pm_r == RWU_PM_WAIT);
      o_stop_mode <= (pm_r == RWU_PM_STOP);
    end
  end

  // ------------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------------
  assign acc     = i_psel && i_penable;
  assign wr_fire = acc && o_pready && i_pwrite && i_pstrb[0];
  assign idx     = i_paddr[9:2];
  assign slot    = slot_of(idx);
  assign hit     = (i_paddr[11:10] == 2'b00) && (i_paddr[1:0] == 2'b00)
                   && (slot != NO_SLOT || idx == `RWU_IDX_WDG || idx == `RWU_IDX_STATUS);
  assign wb      = i_pwdata[7:0];

  // ------------------------------------------------------------------
  // watchdog
  // ------------------------------------------------------------------
  assign wdg_step = tick && !frozen && (pre_r == PRE_LAST);

  // prescaler paces the downcounter
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || in_reset) begin
      pre_r <= 8'h00;
    end else if (tick && !frozen) begin
      pre_r <= (pre_r == PRE_LAST) ? 8'h00 : pre_r + 8'h01;
    end
  end

  // downcounter, reload and activation
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || in_reset) begin
      cnt_r <= {WDG_RST[`RWU_WDG_SR_BIT], rev6(WDG_RST[7:2])};
      act_r <= WDG_RST[`RWU_WDG_ACT_BIT];
    end else if (wr_fire && idx == `RWU_IDX_WDG) begin
      cnt_r <= {wb[`RWU_WDG_SR_BIT], rev6(wb[7:2])};
      act_r <= act_r | wb[`RWU_WDG_ACT_BIT];
    end else if (wdg_step) begin
      cnt_r <= cnt_r - 7'h01;
    end
  end

  // expiry and software reset pulses
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || in_reset) begin
      wdg_fire_r <= 1'b0;
      sw_fire_r  <= 1'b0;
    end else begin
      wdg_fire_r <= wdg_step && wdg_act && (cnt_r == 7'h40)
                    && !(wr_fire && idx == `RWU_IDX_WDG);
      sw_fire_r  <= wr_fire && idx == `RWU_IDX_WDG && cnt_r[6]
                    && !wb[`RWU_WDG_SR_BIT];
    end
  end

  assign wdg_rd = {rev6(cnt_r[5:0]), cnt_r[6], wdg_act};

  // ------------------------------------------------------------------
  // plain registers and status
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    for (int s = 0; s < NSLOT; s++) begin
      if (i_reset || in_reset) begin
        plain_r[s] <= slot_rst(s);
      end else if (wr_fire && slot == 4'(s)) begin
        plain_r[s] <= wb;
      end
    end
  end

  // sticky reset causes, set wins over write-one clear
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      cause_r <= 4'h0;
    end else begin
      cause_r <= (cause_r & ~((wr_fire && idx == `RWU_IDX_STATUS) ? wb[3:0] : 4'h0))
                 | {sw_fire_r, wdg_fire_r, por_s, ~pin_n_s};
    end
  end

  assign stat_rd = {o_stop_mode, o_wait_mode, wdg_act, o_core_ctl.nmi_mode, cause_r};

  // ------------------------------------------------------------------
  // apb answer, one wait state
  // ------------------------------------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_reset) begin
      o_pready  <= 1'b0;
      o_pslverr <= 1'b0;
      o_prdata  <= 32'h0000_0000;
    end else begin
      o_pready  <= acc && !o_pready;
      o_pslverr <= acc && !o_pready && !hit;
      if (acc && !o_pready) begin
        if (!hit || i_pwrite || slot == 4'h6) begin
          o_prdata <= 32'h0000_0000;
        end else if (idx == `RWU_IDX_WDG) begin
          o_prdata <= {24'h00_0000, wdg_rd};
        end else if (idx == `RWU_IDX_STATUS) begin
          o_prdata <= {24'h00_0000, stat_rd};
        end else begin
          o_prdata <= {24'h00_0000, plain_r[slot]};
        end
      end
    end
  end
endmodule : rwu_top

/* tb/rwu_asserts.sv */
// concurrent checks on the ports of the reset and watchdog unit
`timescale 1ns/1ps
module rwu_asserts (
  input  wire logic                   i_ref_clk,
  input  wire logic                   i_reset,
  input  wire logic                   i_reset_pin_n,
  input  wire logic                   i_por,
  input  wire rwu_pkg::rwu_core_evt_t i_core_evt,
  input  wire logic                   o_int_reset,
  input  wire logic                   o_io_pullup,
  input  wire logic                   o_osc_restart,
  input  wire logic                   o_osc_off,
  input  wire rwu_pkg::rwu_core_ctl_t o_core_ctl
);
  import rwu_pkg::*;
  logic [11:0] hi_cnt_r;

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_reset);

  // consecutive cycles with the internal reset high, saturating
  always_ff @(posedge i_ref_clk) begin
    if (i_reset || !o_int_reset) begin
      hi_cnt_r <= 12'h000;
    end else if (hi_cnt_r != 12'hFFF) begin
      hi_cnt_r <= hi_cnt_r + 12'h001;
    end
  end

  // ------------------------------------------------------------------
  // reset sources and reset state
  // ------------------------------------------------------------------
  AST_PULLUP: assert property (o_io_pullup == o_int_reset)
    else $error("pull-up state differs from internal reset");
  AST_HALT: assert property (o_core_ctl.halt == o_int_reset)
    else $error("core halt differs from internal reset");
  AST_PIN_HOLD: assert property ((!i_reset_pin_n) [*7] |-> o_int_reset)
    else $error("reset pin held low without internal reset");
  AST_POR_HOLD: assert property (i_por [*7] |-> o_int_reset)
    else $error("power-on held without internal reset");
  AST_DELAY: assert property ($fell(o_int_reset) |-> hi_cnt_r >= 12'd2048)
    else $error("internal reset released before the delay ran out");
  AST_VECTOR: assert property ($fell(o_int_reset) |-> o_core_ctl.pc_load &&
      o_core_ctl.stack_clear && o_core_ctl.pc_vector == 12'hFFE)
    else $error("no stack clear or vector load at release");
  AST_NMI_RESET: assert property (o_int_reset |-> o_core_ctl.nmi_mode)
    else $error("nmi mode not set in reset");
  AST_IRQ_SVC: assert property (o_core_ctl.nmi_mode && i_core_evt.return_from_interrupt &&
      i_core_evt.irq_pending && !o_int_reset |=> o_core_ctl.irq_service && !o_core_ctl.nmi_mode)
    else $error("pending interrupt not serviced after return");
  AST_OSC_OFF: assert property (o_int_reset |-> !o_osc_off)
    else $error("oscillator off while in reset");
  AST_RESTART: assert property ($rose(o_osc_restart) |-> ##[0:3] o_int_reset)
    else $error("oscillator restart without reset");
endmodule : rwu_asserts

bind rwu_top rwu_asserts chk_u (.i_ref_clk, .i_reset, .i_reset_pin_n, .i_por, .i_core_evt,
  .o_int_reset, .o_io_pullup, .o_osc_restart, .o_osc_off, .o_core_ctl);

/* tb/rwu_core_model.sv */
// core and external reset circuit model driving the far-side inputs
`timescale 1ns/1ps
module rwu_core_model (
  input  wire logic              i_ref_clk,
  output logic                   o_reset_pin_n,
  output logic                   o_por,
  output logic                   o_nmi_pin,
  output rwu_pkg::rwu_core_evt_t o_core_evt
);
  import rwu_pkg::*;

  // idle levels: pin released high, supply settled, nmi low
  initial begin
    o_reset_pin_n = 1'b1;
    o_por         = 1'b0;
    o_nmi_pin     = 1'b0;
    o_core_evt    = '0;
  end

  // hold the reset pin low for n cycles, then release it
  task automatic pin_reset(input int n);
    @(posedge i_ref_clk);
    o_reset_pin_n <= 1'b0;
    repeat (n) @(posedge i_ref_clk);
    o_reset_pin_n <= 1'b1;
  endtask : pin_reset

  // power-on detector active for n cycles
  task automatic por_pulse(input int n);
    @(posedge i_ref_clk);
    o_por <= 1'b1;
    repeat (n) @(posedge i_ref_clk);
    o_por <= 1'b0;
  endtask : por_pulse

  // one-cycle core event
  task automatic evt(input rwu_core_evt_t e);
    @(posedge i_ref_clk);
    o_core_evt <= e;
    @(posedge i_ref_clk);
    o_core_evt <= '0;
  endtask : evt

  // drive the nmi pin to a new level from the next edge on
  task automatic set_nmi(input logic v);
    @(posedge i_ref_clk);
    o_nmi_pin <= v;
  endtask : set_nmi
endmodule : rwu_core_model

/* tb/tb.sv */
// self-checking bench of the reset and watchdog unit
`timescale 1ns/1ps
module tb;
  import rwu_pkg::*;
  logic          clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic          int_rst, pull, osc_rs, osc_off, wait_m, stop_m, pin_n, por, nmi;
  logic          hw_opt, ext_stop;
  logic [3:0]    pstrb;
  logic [11:0]   paddr;
  logic [31:0]   pwdata, prdata, rd;
  rwu_core_evt_t evt;
  rwu_core_ctl_t ctl;
  int            n_errors, compares, c;
  localparam logic [7:0] IDX_T [11] = '{8'hD8, 8'hD1, 8'hD2, 8'hD3, 8'hC0, 8'hC1, 8'hC4,
                                        8'hC5, 8'hCC, 8'hCD, 8'hD4};
  localparam logic [7:0] VAL_T [11] = '{8'hFE, 8'h40, 8'h7F, 8'hFF, 8'h00, 8'h00, 8'h00,
                                        8'h00, 8'h00, 8'h00, 8'h00};

  rwu_core_model core_u (.i_ref_clk(clk), .o_reset_pin_n(pin_n), .o_por(por),
                         .o_nmi_pin(nmi), .o_core_evt(evt));
  rwu_top dut_u (.i_ref_clk(clk), .i_reset(rst), .i_reset_pin_n(pin_n), .i_por(por),
    .i_nmi_pin(nmi), .i_opt_hw_wdg(hw_opt), .i_opt_ext_stop(ext_stop), .i_core_evt(evt),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr),
    .i_pwdata(pwdata), .i_pstrb(pstrb), .o_prdata(prdata), .o_pready(pready),
    .o_pslverr(pslverr), .o_int_reset(int_rst), .o_io_pullup(pull),
    .o_osc_restart(osc_rs), .o_osc_off(osc_off), .o_wait_mode(wait_m),
    .o_stop_mode(stop_m), .o_core_ctl(ctl));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // verdict and end of run
  task automatic conclude();
    $display("compares=%0d n_errors=%0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
    int k;
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= {24'h000000, wd};
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 20);
    rd = prdata;
    er = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    if (k >= 20) begin
      n_errors++;
      conclude();
    end
  endtask : apb

  // wait for the internal reset to reach level v, counting edges
  task automatic wait_rst(input logic v, input int lim);
    c = 0;
    while (int_rst !== v && c < lim) begin
      @(posedge clk);
      c++;
    end
    if (c >= lim) begin
      n_errors++;
      conclude();
    end
  endtask : wait_rst

  initial begin
    n_errors = 0;
    compares = 0;
    rst      = 1'b1;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 12'h000;
    pwdata   = 32'h00000000;
    hw_opt   = 1'b0;
    ext_stop = 1'b0;
    pstrb    = 4'hF;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    wait_rst(1'b0, 3000);
    for (int i = 0; i < 11; i++) begin
      apb(1'b0, IDX_T[i], 8'h00);
      chk(rd, {24'h000000, VAL_T[i]});
    end
    chk(ctl.nmi_mode, 1'b1);
    core_u.evt(5'b00011);
    @(posedge clk);
    chk({ctl.irq_service, ctl.nmi_mode}, 2'b10);
    $display("test reset values done");
    // wait and stop entry with the watchdog idle
    for (int i = 0; i < 2; i++) begin
      core_u.evt(i == 0 ? 5'b01000 : 5'b10000);
      repeat (2) @(posedge clk);
      chk({wait_m, stop_m}, i == 0 ? 2'b10 : 2'b01);
      core_u.evt(5'b00100);
      repeat (2) @(posedge clk);
      chk({wait_m, stop_m}, 2'b00);
    end
    apb(1'b0, 8'h00, 8'h00);
    chk({31'h0, er}, 32'h00000001);
    chk(rd, 32'h00000000);
    $display("test modes and unmapped done");
    apb(1'b1, 8'hD8, 8'h86);
    apb(1'b0, 8'hD8, 8'h00);
    chk(rd, 32'h00000086);
    // active watchdog, lsb only in bit 7: two prescaled watchdog steps to expiry
    apb(1'b1, 8'hD8, 8'h83);
    core_u.evt(5'b10000);
    repeat (2) @(posedge clk);
    chk(wait_m, 1'b1);
    core_u.evt(5'b00100);
    wait_rst(1'b1, 7000);
    chk(c > 3060 && c < 6150, 1'b1);
    wait_rst(1'b0, 3000);
    apb(1'b0, 8'hD8, 8'h00);
    chk(rd, 32'h000000FE);
    apb(1'b0, 8'hE1, 8'h00);
    chk(rd[2], 1'b1);
    $display("test watchdog expiry done");
    apb(1'b1, 8'hD8, 8'hFC);
    wait_rst(1'b1, 6);
    wait_rst(1'b0, 3000);
    apb(1'b0, 8'hE1, 8'h00);
    chk(rd[3], 1'b1);
    $display("test software reset done");
    // strobe-less write ignored, then oscillator off bit
    pstrb <= 4'hE;
    apb(1'b1, 8'hD1, 8'h44);
    pstrb <= 4'hF;
    apb(1'b0, 8'hD1, 8'h00);
    chk(rd, 32'h00000040);
    apb(1'b1, 8'hD1, 8'h44);
    repeat (2) @(posedge clk);
    chk(osc_off, 1'b1);
    apb(1'b1, 8'hE1, 8'h0F);
    $display("test strobe and oscillator off done");
    core_u.pin_reset(3);
    wait_rst(1'b1, 20);
    wait_rst(1'b0, 3000);
    chk(c >= 2049 && c <= 2056, 1'b1);
    chk(osc_off, 1'b0);
    apb(1'b0, 8'hE1, 8'h00);
    chk(rd[3:0], 4'h1);
    apb(1'b0, 8'hD1, 8'h00);
    chk(rd, 32'h00000040);
    // hardware activation with external stop control
    hw_opt   <= 1'b1;
    ext_stop <= 1'b1;
    core_u.pin_reset(8);
    wait_rst(1'b1, 20);
    wait_rst(1'b0, 3000);
    apb(1'b0, 8'hD8, 8'h00);
    chk(rd, 32'h000000FF);
    for (int i = 0; i < 2; i++) begin
      if (i == 1) core_u.set_nmi(1'b1);
      repeat (6) @(posedge clk);
      core_u.evt(5'b10000);
      repeat (2) @(posedge clk);
      chk({wait_m, stop_m}, i == 0 ? 2'b10 : 2'b01);
      core_u.evt(5'b00100);
    end
    core_u.set_nmi(1'b0);
    hw_opt   <= 1'b0;
    ext_stop <= 1'b0;
    $display("test pin reset and stop control done");
    apb(1'b1, 8'hE1, 8'h0F);
    core_u.por_pulse(8);
    wait_rst(1'b1, 20);
    wait_rst(1'b0, 3000);
    apb(1'b0, 8'hE1, 8'h00);
    chk(rd[3:0], 4'h2);
    apb(1'b0, 8'hD8, 8'h00);
    chk(rd, 32'h000000FE);
    $display("test power-on reset done");
    conclude();
  end
endmodule : tb
